// >>> src/urx_receiver.sv
// Asynchronous receive front end: clock recovery, data recovery, receive buffer
`timescale 1ns/1ps
module urx_receiver
    import urx_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Serial line
    input wire logic serial_in,
    // Configuration
    input wire logic receiver_enable,
    input wire logic double_speed_select,
    input wire logic [URX_DIV_W-1:0] baud_divisor_value,
    input wire logic [3:0] frame_bits,
    // Receive data location
    input wire logic serial_data_read,
    output logic [URX_FRAME_BITS_MAX-1:0] serial_data_location,
    output logic frame_error_flag,
    output logic receive_complete_flag
);
    // Reset release
    logic rst_meta_reg;
    logic rst_sync_reg;
    wire rst_n = rst_sync_reg;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Serial input synchroniser; only the second stage is looked at
    logic rx_meta_reg;
    logic rx_sync_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end else begin
            rx_meta_reg <= serial_in;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    // Oversampling tick: one pulse every divisor plus one clocks
    logic [URX_DIV_W-1:0] div_cnt_reg;
    wire tick = (div_cnt_reg == URX_DIV_ZERO);
    wire [URX_DIV_W-1:0] div_cnt_next = tick ? baud_divisor_value : div_cnt_reg - 1'b1;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_reg <= URX_DIV_ZERO;
        end else begin
            div_cnt_reg <= div_cnt_next;
        end
    end

    // Mode dependent sample points
    wire [4:0] s_len = double_speed_select ? URX_OVS_DOUBLE : URX_OVS_NORMAL;
    wire [4:0] vote_first = double_speed_select ? URX_VOTE_FIRST_DOUBLE
                                                : URX_VOTE_FIRST_NORMAL;
    wire [4:0] vote_last = vote_first + URX_VOTE_SPAN;
    wire [4:0] rearm_at = vote_last + URX_DS_EXTRA;

    // Recovery state
    urx_state_e state_reg;
    urx_state_e state_next;
    logic [4:0] samp_cnt_reg;
    logic [4:0] samp_cnt_next;
    logic [3:0] bit_idx_reg;
    logic [2:0] vote_reg;
    logic prev_sample_reg;
    logic [URX_FRAME_BITS_MAX-1:0] shift_reg;
    logic frame_err_reg;
    logic pend_reg;

    wire in_vote = (samp_cnt_reg >= vote_first) && (samp_cnt_reg <= vote_last);
    wire [2:0] vote_next = in_vote ? {vote_reg[1:0], rx_sync_reg} : vote_reg;
    wire vote_high = (vote_next[0] & vote_next[1]) | (vote_next[0] & vote_next[2])
                   | (vote_next[1] & vote_next[2]);
    wire at_decide = tick && (samp_cnt_reg == vote_last);
    wire bit_end = tick && (samp_cnt_reg == s_len);
    wire at_stop = (bit_idx_reg == frame_bits);
    wire start_edge = tick && prev_sample_reg && !rx_sync_reg;
    wire noise = at_decide && vote_high;
    wire stop_vote = at_decide && (state_reg == URX_DATA) && at_stop;
    // The edge tick is itself sample one, so the count carries on from two
    wire [4:0] samp_second = URX_SAMPLE_FIRST + 1'b1;

    // Buffer interface; a full buffer holds the finished frame and stalls recovery
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [URX_WORD_W-1:0] fifo_out_data;
    wire [URX_WORD_W-1:0] fifo_in_data = {frame_err_reg, shift_reg};
    wire flush = !receiver_enable;
    // A waiting frame holds off a new start only if it cannot enter the buffer now
    wire rx_blocked = pend_reg && !fifo_in_ready;

    always_comb begin
        state_next = state_reg;
        samp_cnt_next = samp_cnt_reg;
        unique case (state_reg)
            URX_IDLE: begin
                if (start_edge && !rx_blocked) begin
                    state_next = URX_START;
                    samp_cnt_next = samp_second;
                end
            end
            URX_START: begin
                if (noise) begin
                    state_next = URX_IDLE;
                end else if (bit_end) begin
                    state_next = URX_DATA;
                    samp_cnt_next = URX_SAMPLE_FIRST;
                end else if (tick) begin
                    samp_cnt_next = samp_cnt_reg + 1'b1;
                end
            end
            URX_DATA: begin
                if (stop_vote && !double_speed_select) begin
                    state_next = URX_IDLE;
                end else if (stop_vote) begin
                    state_next = URX_HOLD;
                    samp_cnt_next = samp_cnt_reg + 1'b1;
                end else if (bit_end) begin
                    samp_cnt_next = URX_SAMPLE_FIRST;
                end else if (tick) begin
                    samp_cnt_next = samp_cnt_reg + 1'b1;
                end
            end
            URX_HOLD: begin
                // Double speed waits one more sample before taking a new edge
                if (tick && samp_cnt_reg == rearm_at) begin
                    state_next = URX_IDLE;
                end else if (tick) begin
                    samp_cnt_next = samp_cnt_reg + 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= URX_IDLE;
            samp_cnt_reg <= 5'h00;
        end else if (!receiver_enable) begin
            state_reg <= URX_IDLE;
            samp_cnt_reg <= 5'h00;
        end else begin
            state_reg <= state_next;
            samp_cnt_reg <= samp_cnt_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_sample_reg <= 1'b1;
            vote_reg <= 3'h0;
        end else if (tick) begin
            prev_sample_reg <= rx_sync_reg;
            vote_reg <= vote_next;
        end
    end

    // Bit assembly, least significant bit first
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bit_idx_reg <= 4'h0;
            shift_reg <= '0;
            frame_err_reg <= 1'b0;
        end else if (state_reg == URX_START) begin
            bit_idx_reg <= 4'h0;
            if (!pend_reg) shift_reg <= '0;
        end else if (state_reg == URX_DATA && at_decide && !at_stop) begin
            shift_reg[bit_idx_reg] <= vote_high;
            bit_idx_reg <= bit_idx_reg + 1'b1;
        end else if (stop_vote) begin
            frame_err_reg <= !vote_high;
        end
    end

    // Frame waiting to enter the buffer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= 1'b0;
        end else if (!receiver_enable) begin
            pend_reg <= 1'b0;
        end else if (stop_vote) begin
            pend_reg <= 1'b1;
        end else if (fifo_in_ready) begin
            pend_reg <= 1'b0;
        end
    end

    urx_fifo #(
        .WIDTH(URX_WORD_W),
        .DEPTH(URX_BUF_DEPTH)
    ) u_buf (
        .clock(clock),
        .rst_n(rst_n),
        .flush(flush),
        .in_valid(pend_reg),
        .in_data(fifo_in_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(serial_data_read)
    );

    // Registered view of the head of the buffer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            serial_data_location <= '0;
            frame_error_flag <= 1'b0;
            receive_complete_flag <= 1'b0;
        end else begin
            serial_data_location <= fifo_out_valid ? fifo_out_data[URX_FRAME_BITS_MAX-1:0] : '0;
            frame_error_flag <= fifo_out_valid && fifo_out_data[URX_FE_POS];
            receive_complete_flag <= fifo_out_valid;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_edge_seen;
        state_reg == URX_IDLE && receiver_enable && start_edge && !rx_blocked;
    endsequence

    sequence s_start_counting;
        state_reg == URX_START && samp_cnt_reg == samp_second;
    endsequence

    property p_start_detect;
        s_edge_seen |=> s_start_counting;
    endproperty
    a_start_detect: assert property (p_start_detect) else $error("start edge missed");

    property p_noise_reject;
        (receiver_enable && state_reg == URX_START && noise) |=> state_reg == URX_IDLE;
    endproperty
    a_noise_reject: assert property (p_noise_reject) else $error("noise not rejected");

    property p_start_window;
        (receiver_enable && state_reg == URX_START && at_decide && !vote_high)
            |=> state_reg == URX_START && samp_cnt_reg == vote_last + 1'b1;
    endproperty
    a_start_window: assert property (p_start_window) else $error("bad start decision");

    property p_sample_range;
        state_reg != URX_IDLE |-> samp_cnt_reg >= URX_SAMPLE_FIRST && samp_cnt_reg <= s_len;
    endproperty
    a_sample_range: assert property (p_sample_range) else $error("sample number out of range");

    property p_sync_delay;
        ##2 (rx_sync_reg == $past(serial_in, 2));
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("input not two stages late");

    property p_stop_bits;
        stop_vote |-> bit_idx_reg == frame_bits;
    endproperty
    a_stop_bits: assert property (p_stop_bits) else $error("stop voted at wrong bit");

    property p_frame_error;
        (receiver_enable && stop_vote) |=> frame_err_reg == !$past(vote_high) && pend_reg;
    endproperty
    a_frame_error: assert property (p_frame_error) else $error("frame error not recorded");

    property p_normal_rearm;
        (receiver_enable && stop_vote && !double_speed_select) |=> state_reg == URX_IDLE;
    endproperty
    a_normal_rearm: assert property (p_normal_rearm) else $error("late rearm in normal mode");

    property p_disable_flush;
        (!receiver_enable)[*3] |-> !receive_complete_flag;
    endproperty
    a_disable_flush: assert property (p_disable_flush) else $error("buffer kept while off");
endmodule : urx_receiver

// >>> pkg/urx_pkg.sv
// Constants and types for the asynchronous receive front end
// Operation
// - Turning the receiver off empties the receive buffer and drops every unread entry.
// - The serial input is sampled at 16x the bit rate, or 8x when double speed is selected.
// - Start detection begins on a high-to-low change, the first low sample being sample one.
// - The start bit is checked on samples 8, 9, 10 (normal) or 4, 5, 6 (double speed).
// - If two or more of those samples are high the pulse is noise and edge watching resumes.
// - Bit timing is restarted on every accepted start bit.
// - Recovery steps 16 states per bit (normal) or 8 (double speed), numbering each sample.
// - Each data and parity bit is the majority of its three centre samples.
// - Recovery runs up to the first stop bit only; later stop bits are ignored.
// - The stop bit is voted the same way and a zero vote marks a frame error.
// - Normal mode takes a new start edge right after the last stop vote; double speed later.
// - Frames carry five to ten bits of character plus parity.
// - Double speed changes the oversampling divisor from sixteen to eight.
// - The receive buffer is a two-entry queue that advances on each data read.
package urx_pkg;
    localparam logic [4:0] URX_OVS_NORMAL = 5'h10;
    localparam logic [4:0] URX_OVS_DOUBLE = 5'h08;
    localparam logic [4:0] URX_VOTE_FIRST_NORMAL = 5'h08;
    localparam logic [4:0] URX_VOTE_FIRST_DOUBLE = 5'h04;
    localparam logic [4:0] URX_VOTE_SPAN = 5'h02;
    localparam logic [4:0] URX_SAMPLE_FIRST = 5'h01;
    localparam logic [4:0] URX_DS_EXTRA = 5'h01;
    localparam int URX_FRAME_BITS_MAX = 10;
    localparam int URX_DIV_W = 12;
    localparam int URX_BUF_DEPTH = 2;
    localparam int URX_WORD_W = URX_FRAME_BITS_MAX + 1;
    localparam int URX_FE_POS = URX_FRAME_BITS_MAX;
    localparam logic [URX_DIV_W-1:0] URX_DIV_ZERO = 12'h000;

    typedef enum logic [1:0] {
        URX_IDLE = 2'b00,
        URX_START = 2'b01,
        URX_DATA = 2'b11,
        URX_HOLD = 2'b10
    } urx_state_e;
endpackage : urx_pkg

// >>> src/urx_fifo.sv
// Small first-in first-out queue with valid and ready on both sides
`timescale 1ns/1ps
module urx_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;

    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [PW-1:0] wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
    wire [PW-1:0] rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;

    assign in_ready = (count_reg != CNT_FULL) && !flush;
    assign out_valid = (count_reg != '0) && !flush;
    assign out_data = mem[rd_ptr_reg];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (flush) begin
            // Everything unread is dropped at once
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_next;
            if (pop) rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_reg + CW'(push) - CW'(pop);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_depth_bound;
        count_reg <= CNT_FULL;
    endproperty
    a_depth_bound: assert property (p_depth_bound) else $error("queue count above depth");

    property p_pop_advances;
        (pop && !push && !flush) |=> count_reg == $past(count_reg) - 1'b1;
    endproperty
    a_pop_advances: assert property (p_pop_advances) else $error("read did not advance queue");

    property p_flush_empties;
        flush |=> count_reg == '0;
    endproperty
    a_flush_empties: assert property (p_flush_empties) else $error("flush left entries");
endmodule : urx_fifo

// >>> tb/urx_tx_model.sv
// Remote serial transmitter that drives the receive line
`timescale 1ns/1ps
module urx_tx_model (
    // Serial line
    output logic serial_out
);
    // Line idles high between frames
    initial serial_out = 1'b1;

    // Start bit, D bits first bit first, stop bits; bit_ns sets the rate and its error
    task automatic send(input logic [9:0] data, input int nbits, input logic stop_val,
                        input int nstop, input realtime bit_ns);
        serial_out = 1'b0;
        #(bit_ns);
        for (int i = 0; i < nbits; i++) begin
            serial_out = data[i];
            #(bit_ns);
        end
        for (int i = 0; i < nstop; i++) begin
            serial_out = stop_val;
            #(bit_ns);
        end
        serial_out = 1'b1;
    endtask : send

    // Short low glitch on the line, used to probe the start filter
    task automatic pulse(input realtime low_ns);
        serial_out = 1'b0;
        #(low_ns);
        serial_out = 1'b1;
    endtask : pulse

    // Hold the line high so that the next start edge is a real transition
    task automatic idle(input realtime ns);
        serial_out = 1'b1;
        #(ns);
    endtask : idle
endmodule : urx_tx_model

// >>> tb/urx_receiver_test.sv
// Self-checking testbench for the asynchronous receive front end
`timescale 1ns/1ps
module urx_receiver_test;
    import urx_pkg::*;

    logic clock, reset_n, serial_in, receiver_enable, double_speed_select, serial_data_read;
    logic [URX_DIV_W-1:0] baud_divisor_value;
    logic [3:0] frame_bits;
    logic [URX_FRAME_BITS_MAX-1:0] serial_data_location;
    logic frame_error_flag, receive_complete_flag;
    int mismatches, n_compared, cycles;

    urx_receiver dut_u (
        .clock(clock), .reset_n(reset_n), .serial_in(serial_in),
        .receiver_enable(receiver_enable), .double_speed_select(double_speed_select),
        .baud_divisor_value(baud_divisor_value), .frame_bits(frame_bits),
        .serial_data_read(serial_data_read), .serial_data_location(serial_data_location),
        .frame_error_flag(frame_error_flag), .receive_complete_flag(receive_complete_flag)
    );

    urx_tx_model tx_u (
        .serial_out(serial_in)
    );

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic conclude();
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    // Hang guard; a full run needs well under a third of this
    initial begin
        cycles = 0;
        forever @(posedge clock) begin
            cycles++;
            if (cycles > 30000) begin
                mismatches++;
                conclude();
            end
        end
    end

    task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    function automatic logic [11:0] status();
        return {receive_complete_flag, frame_error_flag, serial_data_location};
    endfunction : status

    // Bounded wait for unread data; a whole frame at 16 clocks per bit fits, not one at 32
    task automatic wait_ready();
        for (int i = 0; i < 300 && receive_complete_flag !== 1'b1; i++) step(1);
        step(1);
    endtask : wait_ready

    // Check the head entry, then read it; reads stay at least two idle cycles apart
    task automatic pop(input logic [9:0] exp, input logic fe);
        check(status(), {1'b1, fe, exp}, "head entry");
        serial_data_read = 1'b1;
        step(1);
        serial_data_read = 1'b0;
        step(3);
    endtask : pop

    task automatic mode(input logic dss, input int d);
        double_speed_select = dss;
        frame_bits = 4'(d);
        step(2);
    endtask : mode

    task automatic t_basic();
        mode(1'b0, 8);
        tx_u.send(10'h0A5, 8, 1'b1, 1, 80.0);
        wait_ready();
        pop(10'h0A5, 1'b0);
        check(status(), 12'h000, "empty after read");
        // Divisor one halves the tick rate, so a bit lasts 32 clocks
        baud_divisor_value = 12'h001;
        step(2);
        tx_u.send(10'h05C, 8, 1'b1, 1, 160.0);
        wait_ready();
        pop(10'h05C, 1'b0);
        baud_divisor_value = URX_DIV_ZERO;
        step(2);
    endtask : t_basic

    task automatic t_widths();
        logic [9:0] m;
        for (int s = 0; s < 2; s++) begin
            for (int d = 5; d <= 10; d++) begin
                m = (10'h001 << d) - 10'h001;
                mode(s[0], d);
                tx_u.send(10'h3C9, d, 1'b1, 1, s ? 40.0 : 80.0);
                wait_ready();
                pop(10'h3C9 & m, 1'b0);
            end
        end
    endtask : t_widths

    // Glitch one sample short of a majority is dropped; one sample longer starts a frame
    task automatic t_noise(input logic dss, input realtime unit);
        mode(dss, 8);
        tx_u.pulse(unit * (dss ? 4 : 8));
        step(60);
        check(status(), 12'h000, "glitch dropped");
        tx_u.pulse(unit * (dss ? 5 : 9));
        wait_ready();
        pop(10'h0FF, 1'b0);
    endtask : t_noise

    // Bad stop, then two frames back to back; third one waits while the buffer is full
    task automatic t_stop();
        mode(1'b0, 8);
        tx_u.send(10'h05A, 8, 1'b0, 1, 80.0);
        tx_u.idle(80.0);
        tx_u.send(10'h0C3, 8, 1'b1, 2, 80.0);
        tx_u.send(10'h011, 8, 1'b1, 1, 80.0);
        wait_ready();
        pop(10'h05A, 1'b1);
        pop(10'h0C3, 1'b0);
        pop(10'h011, 1'b0);
        check(status(), 12'h000, "drained");
    endtask : t_stop

    // Far end off nominal rate within the recommended error; no line change hits a clock edge
    task automatic t_rate();
        realtime bit_ns [4] = '{81.2, 78.81, 40.39, 39.6};
        for (int i = 0; i < 4; i++) begin
            mode(i >= 2, 10);
            tx_u.send(10'h2D3, 10, 1'b1, 1, bit_ns[i]);
            wait_ready();
            pop(10'h2D3, 1'b0);
        end
    endtask : t_rate

    task automatic t_flush();
        mode(1'b0, 6);
        tx_u.send(10'h015, 6, 1'b1, 1, 80.0);
        tx_u.send(10'h02A, 6, 1'b1, 1, 80.0);
        wait_ready();
        check(status(), {2'b10, 10'h015}, "queued before flush");
        receiver_enable = 1'b0;
        step(2);
        check(status(), 12'h000, "flushed on disable");
        receiver_enable = 1'b1;
        step(4);
        check(status(), 12'h000, "still empty");
    endtask : t_flush

    // Software drain loop: read until the complete flag drops
    task automatic t_drain();
        int n;
        mode(1'b1, 7);
        tx_u.send(10'h055, 7, 1'b1, 1, 40.0);
        tx_u.send(10'h02B, 7, 1'b1, 1, 40.0);
        wait_ready();
        n = 0;
        while (receive_complete_flag === 1'b1 && n < 4) begin
            serial_data_read = 1'b1;
            step(1);
            serial_data_read = 1'b0;
            step(3);
            n++;
        end
        check(12'(n), 12'h002, "reads to drain");
        check(status(), 12'h000, "drained by reads");
    endtask : t_drain

    initial begin
        mismatches = 0;
        n_compared = 0;
        reset_n = 1'b0;
        receiver_enable = 1'b1;
        double_speed_select = 1'b0;
        baud_divisor_value = URX_DIV_ZERO;
        frame_bits = 4'h8;
        serial_data_read = 1'b0;
        repeat (8) @(posedge clock);
        #1;
        check(status(), 12'h000, "outputs in reset");
        reset_n = 1'b1;
        step(3);
        t_basic();
        t_widths();
        t_noise(1'b0, 5.0);
        t_noise(1'b1, 5.0);
        t_stop();
        t_rate();
        t_flush();
        t_drain();
        conclude();
    end
endmodule : urx_receiver_test
